// File: dv/pint_pad_model.sv
// Pad model: quiet pins follow the bench, the rest chatter
`default_nettype none
module pint_pad_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [63:0] lvl,
   input  wire logic [63:0] quiet,
   output logic      [63:0] port_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] noise_reg;
   // Unselected pins toggle every cycle so a bad selector shows up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) noise_reg <= 64'h0;
      else noise_reg <= ~noise_reg;
   end
   assign port_pins = (lvl & quiet) | (noise_reg & ~quiet);
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the pin interrupt and pattern match top
`default_nettype none
`include "pint_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [18:0] ALL = 19'h7FFFF;
   localparam logic [18:0] NOWK = 19'h7FFFE;
   logic                           clk, rst_n, pm_enable, pm_event_en, ev_sig, ev_pin, wake_req;
   logic [63:0]                    lvl, quiet, port_pins;
   logic [7:0]                     slot_clear, wse, slot_irq, term_irq;
   pint_pkg::pint_slot_cfg_s [7:0] slot_cfg;
   pint_pkg::pint_pm_cfg_s [7:0]   pm_cfg;
   pint_pkg::pint_pwr_e            power_mode;
   logic [18:0]                    exp_q[$], msk_q[$], outs, e, m;
   logic [15:0]                    r;
   logic [5:0]                     base;
   int                             n_fail, cmp_count, cyc;
   assign outs = {slot_irq, term_irq, ev_sig, ev_pin, wake_req};
   pint_pad_model u_pint_pad_model (.clk(clk), .rst_n(rst_n), .lvl(lvl), .quiet(quiet),
      .port_pins(port_pins));
   pint_top u_pint_top (.clk(clk), .rst_n(rst_n), .port_pins(port_pins), .slot_cfg(slot_cfg),
      .slot_clear(slot_clear), .pm_enable(pm_enable), .pm_cfg(pm_cfg),
      .pm_event_en(pm_event_en), .power_mode(power_mode), .wake_start_enable_0(wse),
      .slot_irq(slot_irq), .term_irq(term_irq), .cpu_event_signal(ev_sig),
      .cpu_event_pin(ev_pin), .wake_req(wake_req));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [5:0] pin_of(input int s);
      return base + 6'(s * 8);
   endfunction
   function automatic logic [18:0] vec(input logic [7:0] si, input logic [7:0] ti,
                                       input logic ev, input logic wk);
      return {si, ti, ev, ev, wk};
   endfunction
   task automatic note(input logic [18:0] ex, input logic [18:0] mk);
      exp_q.push_back(ex);
      msk_q.push_back(mk);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic put_pin(input int s, input logic v);
      @(posedge clk);
      lvl[pin_of(s)] <= v;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(negedge clk) begin
      if (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         cmp_count++;
         if (((outs ^ e) & m) !== 19'h0) begin
            n_fail++;
            $display("wrong value at %0t: outputs %h expected %h", $time, outs, e);
         end
      end
   end
   // Run takes about 270 cycles; generous ceiling
   always @(posedge clk) begin
      cyc++;
      if (cyc > 6000) begin
         n_fail++;
         $display("wrong value at %0t: timeout", $time);
         complete_run();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      lvl = '0;
      quiet = '0;
      slot_clear = '0;
      wse = '0;
      pm_enable = 1'b0;
      pm_event_en = 1'b0;
      power_mode = pint_pkg::PINT_PWR_ACTIVE;
      r = lfsr(16'h000D);
      base = r[5:0];
      for (int s = 0; s < 8; s++) begin
         slot_cfg[s] = '{pin_of(s), `PINT_MODE_EDGE, 1'b0, 1'b0};
         pm_cfg[s] = '{`PINT_PM_ZERO, 1'b1};
         quiet[pin_of(s)] = 1'b1;
      end
      step(20);
      rst_n <= 1'b1;
      step(4);
      for (int s = 0; s < 8; s++) begin
         logic [1:0] rf;
         rf = (s % 3 == 0) ? 2'b10 : (s % 3 == 1) ? 2'b01 : 2'b11;
         @(posedge clk);
         slot_cfg[s] <= '{pin_of(s), `PINT_MODE_EDGE, rf[1], rf[0]};
         for (int d = 1; d >= 0; d--) begin
            put_pin(s, d[0]);
            step(3);
            note(19'h0, ALL);
            step(1);
            note(vec(8'(rf[d]) << s, 8'h0, 1'b0, 1'b0), ALL);
            step(2);
            note(vec(8'(rf[d]) << s, 8'h0, 1'b0, 1'b0), ALL);
            slot_clear[s] <= 1'b1;
            step(1);
            slot_clear[s] <= 1'b0;
         end
         slot_cfg[s] <= '{pin_of(s), `PINT_MODE_EDGE, 1'b0, 1'b0};
      end
      $display("edge slot test done");
      power_mode <= pint_pkg::PINT_PWR_DEEP;
      wse <= 8'h04;
      for (int pol = 1; pol >= 0; pol--) begin
         @(posedge clk);
         slot_cfg[2] <= '{pin_of(2), `PINT_MODE_LEVEL, 1'b1, pol[0]};
         for (int v = 1; v >= 0; v--) begin
            put_pin(2, v[0]);
            step(2);
            note(vec(8'(v[0] != pol[0]) << 2, 8'h0, 1'b0, 1'b0), NOWK);
            step(1);
            note(vec(8'(v[0] == pol[0]) << 2, 8'h0, 1'b0, 1'b0), NOWK);
            step(3);
            note(vec(8'(v[0] == pol[0]) << 2, 8'h0, 1'b0, v[0] == pol[0]), ALL);
         end
      end
      $display("level slot test done");
      slot_cfg[2] <= '{pin_of(2), `PINT_MODE_EDGE, 1'b0, 1'b0};
      wse <= 8'h00;
      power_mode <= pint_pkg::PINT_PWR_ACTIVE;
      pm_enable <= 1'b1;
      for (int k = `PINT_PM_RISE; k <= `PINT_PM_EDGE; k++) begin
         @(posedge clk);
         pm_cfg[0] <= '{3'(k), 1'b1};
         pm_event_en <= k[0];
         for (int d = 1; d >= 0; d--) begin
            logic h;
            h = (k == `PINT_PM_EDGE) || (k == `PINT_PM_RISE) == (d == 1);
            put_pin(0, d[0]);
            step(2);
            note(19'h0, NOWK);
            step(1);
            note(vec(8'h0, 8'(h), h & k[0], 1'b0), NOWK);
            step(1);
            note(19'h0, NOWK);
         end
      end
      @(posedge clk);
      pm_cfg[0] <= '{`PINT_PM_RISE, 1'b0};
      pm_cfg[1] <= '{`PINT_PM_HIGH, 1'b1};
      pm_event_en <= 1'b1;
      for (int q = 0; q < 2; q++) begin
         put_pin(1, q[0]);
         step(3);
         put_pin(0, 1'b1);
         step(3);
         note(vec(8'h0, 8'(q) << 1, q[0], 1'b0), 19'h7FFF6);
         put_pin(0, 1'b0);
         step(3);
      end
      $display("pattern test done");
      @(posedge clk);
      pm_cfg[0] <= '{`PINT_PM_HIGH, 1'b1};
      pm_cfg[1] <= '{`PINT_PM_ZERO, 1'b1};
      put_pin(0, 1'b1);
      for (int w = 2; w >= 0; w--) begin
         @(posedge clk);
         power_mode <= pint_pkg::pint_pwr_e'(w);
         step(4);
         note(vec(8'h0, 8'h01, 1'b0, w != 2), 19'h7FFF9);
      end
      @(posedge clk);
      pm_enable <= 1'b0;
      step(4);
      note(19'h0, ALL);
      step(2);
      $display("wake test done");
      complete_run();
   end
endmodule
`default_nettype wire

// File: rtl/pint_consts.svh
// Constants for the pin interrupt and pattern match block
`ifndef PINT_CONSTS_SVH
`define PINT_CONSTS_SVH
`define PINT_NUM_SLOTS     8
`define PINT_PORT_PINS     64
`define PINT_SEL_W         6
`define PINT_SYNC_STAGES   2
// Slot mode field encoding
`define PINT_MODE_EDGE     1'h0
`define PINT_MODE_LEVEL    1'h1
// Pattern input kind encodings
`define PINT_PM_HIGH       3'h0
`define PINT_PM_LOW        3'h1
`define PINT_PM_RISE       3'h2
`define PINT_PM_FALL       3'h3
`define PINT_PM_EDGE       3'h4
`define PINT_PM_ONE        3'h5
`define PINT_PM_ZERO       3'h6
`endif

// File: rtl/pint_pkg.sv
// Types shared by the pin interrupt and pattern match block
`default_nettype none
package pint_pkg;
   // Per-slot configuration
   typedef struct packed {
      logic [5:0] pin_sel;   // Port 0/1 pin number
      logic       mode;      // 0 edge, 1 level
      logic       rise_en;   // Edge: rising; level: enable
      logic       fall_en;   // Edge: falling; level: high-active
   } pint_slot_cfg_s;

   // Per-term pattern configuration
   typedef struct packed {
      logic [2:0] kind;      // Level/transition selector
      logic       term_end;  // Closes a product term here
   } pint_pm_cfg_s;

   typedef enum logic [1:0] {PINT_PWR_ACTIVE, PINT_PWR_SLEEP, PINT_PWR_DEEP} pint_pwr_e;
endpackage
`default_nettype wire

// File: rtl/pint_slot.sv
// One pin interrupt slot: synchroniser, edge detect and request
`default_nettype none
`include "pint_consts.svh"
module pint_slot (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    pin_in,
   input  wire pint_pkg::pint_slot_cfg_s cfg,
   input  wire logic                    clear_edge,
   output logic                         req,
   output logic                         level,
   output logic                         rise,
   output logic                         fall
);
   logic sync1_reg, sync1_next;
   logic sync2_reg, sync2_next;
   logic prev_reg,  prev_next;
   logic held_reg,  held_next;
   logic set_w;

   always_comb begin
      sync1_next = pin_in;
      sync2_next = sync1_reg;
      prev_next  = sync2_reg;
      rise       = sync2_reg & ~prev_reg;
      fall       = ~sync2_reg & prev_reg;
      level      = sync2_reg;
      held_next  = held_reg;
      set_w      = (cfg.mode == `PINT_MODE_EDGE)
                 && ((cfg.rise_en && rise) || (cfg.fall_en && fall));
      // Level mode never arms the latch, so a later switch to edge starts clean
      if (clear_edge || cfg.mode == `PINT_MODE_LEVEL) begin
         held_next = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (set_w) begin
         held_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
         held_reg  <= 1'b0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg  <= prev_next;
         held_reg  <= held_next;
      end
   end

   always_comb begin
      if (cfg.mode == `PINT_MODE_LEVEL) begin
         req = cfg.rise_en & (cfg.fall_en ? sync2_reg : ~sync2_reg);
      end else begin
         req = held_reg;
      end
   end

   property p_edge_once;
      @(posedge clk) disable iff (!rst_n)
      rise |=> !rise;
   endproperty
   a_edge_once : assert property (p_edge_once)
      else $error("rise flagged two cycles running");

   property p_fall_once;
      @(posedge clk) disable iff (!rst_n)
      fall |=> !fall;
   endproperty
   a_fall_once : assert property (p_fall_once)
      else $error("fall flagged two cycles running");

   property p_set_wins;
      @(posedge clk) disable iff (!rst_n)
      set_w |=> held_reg;
   endproperty
   a_set_wins : assert property (p_set_wins)
      else $error("selected edge not held");

   property p_clear_edge;
      @(posedge clk) disable iff (!rst_n)
      (clear_edge && !set_w) |=> !held_reg;
   endproperty
   a_clear_edge : assert property (p_clear_edge)
      else $error("held edge survived a clear");

   property p_edge_hold;
      @(posedge clk) disable iff (!rst_n)
      (cfg.mode == `PINT_MODE_EDGE && held_reg && !clear_edge) |=> held_reg;
   endproperty
   a_edge_hold : assert property (p_edge_hold)
      else $error("held edge dropped without clear");

   property p_level_no_hold;
      @(posedge clk) disable iff (!rst_n)
      (cfg.mode == `PINT_MODE_LEVEL) |=> !held_reg;
   endproperty
   a_level_no_hold : assert property (p_level_no_hold)
      else $error("edge latch armed in level mode");
endmodule
`default_nettype wire

// File: rtl/pint_top.sv
// Pin interrupt and pattern match engine, top level
`default_nettype none
`include "pint_consts.svh"
module pint_top #(
   parameter int N_SLOTS = `PINT_NUM_SLOTS
) (
   input  wire logic                                  clk,
   input  wire logic                                  rst_n,
   input  wire logic [`PINT_PORT_PINS-1:0]            port_pins,
   input  wire pint_pkg::pint_slot_cfg_s [N_SLOTS-1:0] slot_cfg,
   input  wire logic [N_SLOTS-1:0]                    slot_clear,
   input  wire logic                                  pm_enable,
   input  wire pint_pkg::pint_pm_cfg_s [N_SLOTS-1:0]  pm_cfg,
   input  wire logic                                  pm_event_en,
   input  wire pint_pkg::pint_pwr_e                   power_mode,
   input  wire logic [N_SLOTS-1:0]                    wake_start_enable_0,
   output logic [N_SLOTS-1:0]                         slot_irq,
   output logic [N_SLOTS-1:0]                         term_irq,
   output logic                                       cpu_event_signal,
   output logic                                       cpu_event_pin,
   output logic                                       wake_req
);
   // ----------------------------------------------------------------
   // Slots
   // ----------------------------------------------------------------
   logic [N_SLOTS-1:0] req_w, lvl_w, rise_w, fall_w;

   genvar g;
   generate
      for (g = 0; g < N_SLOTS; g++) begin : g_slot
         pint_slot u_slot (
            .clk        (clk),
            .rst_n      (rst_n),
            .pin_in     (port_pins[slot_cfg[g].pin_sel]),
            .cfg        (slot_cfg[g]),
            .clear_edge (slot_clear[g]),
            .req        (req_w[g]),
            .level      (lvl_w[g]),
            .rise       (rise_w[g]),
            .fall       (fall_w[g])
         );

         // Per-slot checks sit with the slot they watch
         property p_level_high;
            @(posedge clk) disable iff (!rst_n)
            (slot_cfg[g].mode && slot_cfg[g].rise_en && slot_cfg[g].fall_en && lvl_w[g])
            |=> slot_irq[g];
         endproperty
         a_level_high : assert property (p_level_high)
            else $error("high level slot not requesting");

         property p_level_low;
            @(posedge clk) disable iff (!rst_n)
            (slot_cfg[g].mode && slot_cfg[g].rise_en && !slot_cfg[g].fall_en && !lvl_w[g])
            |=> slot_irq[g];
         endproperty
         a_level_low : assert property (p_level_low)
            else $error("low level slot not requesting");

         property p_level_idle;
            @(posedge clk) disable iff (!rst_n)
            (slot_cfg[g].mode && slot_cfg[g].fall_en && !lvl_w[g]) |=> !slot_irq[g];
         endproperty
         a_level_idle : assert property (p_level_idle)
            else $error("high active slot requesting while pin low");

         property p_rise_req;
            @(posedge clk) disable iff (!rst_n)
            (!slot_cfg[g].mode && slot_cfg[g].rise_en && rise_w[g] && !slot_clear[g])
            |=> ##1 slot_irq[g];
         endproperty
         a_rise_req : assert property (p_rise_req)
            else $error("rising edge slot not requesting");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pattern match: each input slice is a literal; a slice with
   // term_end closes the product of itself and preceding open slices
   // ----------------------------------------------------------------
   logic [N_SLOTS-1:0] lit;
   logic [N_SLOTS-1:0] term_hit;
   logic               prod;

   always_comb begin
      for (int i = 0; i < N_SLOTS; i++) begin
         unique case (pm_cfg[i].kind)
            `PINT_PM_HIGH: lit[i] = lvl_w[i];
            `PINT_PM_LOW:  lit[i] = ~lvl_w[i];
            `PINT_PM_RISE: lit[i] = rise_w[i];
            `PINT_PM_FALL: lit[i] = fall_w[i];
            `PINT_PM_EDGE: lit[i] = rise_w[i] | fall_w[i];
            `PINT_PM_ONE:  lit[i] = 1'b1;
            default:       lit[i] = 1'b0;
         endcase
      end
      prod = 1'b1;
      for (int i = 0; i < N_SLOTS; i++) begin
         prod        = prod & lit[i];
         term_hit[i] = pm_enable & pm_cfg[i].term_end & prod;
         if (pm_cfg[i].term_end) begin
            prod = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs, registered
   // ----------------------------------------------------------------
   logic [N_SLOTS-1:0] slot_irq_reg, slot_irq_next;
   logic [N_SLOTS-1:0] term_irq_reg, term_irq_next;
   logic               event_reg,    event_next;
   logic               wake_reg,     wake_next;

   always_comb begin
      slot_irq_next = req_w;
      term_irq_next = term_hit;
      event_next    = pm_event_en & (|term_hit);
      // Pattern engine runs from the block clock, absent in deep-sleep
      wake_next     = (|(req_w & wake_start_enable_0))
                    | ((|term_hit) && power_mode != pint_pkg::PINT_PWR_DEEP);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_irq_reg <= '0;
         term_irq_reg <= '0;
         event_reg    <= 1'b0;
         wake_reg     <= 1'b0;
      end else begin
         slot_irq_reg <= slot_irq_next;
         term_irq_reg <= term_irq_next;
         event_reg    <= event_next;
         wake_reg     <= wake_next;
      end
   end

   assign slot_irq         = slot_irq_reg;
   assign term_irq         = term_irq_reg;
   assign cpu_event_signal = event_reg;
   assign cpu_event_pin    = event_reg;
   assign wake_req         = wake_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_event_follows_term;
      @(posedge clk) disable iff (!rst_n)
      (pm_event_en && (|term_hit)) |=> cpu_event_signal;
   endproperty
   a_event_follows_term : assert property (p_event_follows_term)
      else $error("event missing after term match");

   property p_no_event_off;
      @(posedge clk) disable iff (!rst_n)
      !pm_event_en |=> !cpu_event_signal;
   endproperty
   a_no_event_off : assert property (p_no_event_off)
      else $error("event raised while disabled");

   property p_pin_mirror;
      @(posedge clk) disable iff (!rst_n)
      cpu_event_pin == cpu_event_signal;
   endproperty
   a_pin_mirror : assert property (p_pin_mirror)
      else $error("event pin differs from event");

   property p_term_irq;
      @(posedge clk) disable iff (!rst_n)
      term_irq_reg == $past(term_hit);
   endproperty
   a_term_irq : assert property (p_term_irq)
      else $error("term interrupt not following term");

   property p_no_pm_off;
      @(posedge clk) disable iff (!rst_n)
      !pm_enable |=> (term_irq == '0);
   endproperty
   a_no_pm_off : assert property (p_no_pm_off)
      else $error("term interrupt while pattern engine off");

   property p_deep_no_pm_wake;
      @(posedge clk) disable iff (!rst_n)
      (power_mode == pint_pkg::PINT_PWR_DEEP && !(|(req_w & wake_start_enable_0)))
      |=> !wake_req;
   endproperty
   a_deep_no_pm_wake : assert property (p_deep_no_pm_wake)
      else $error("pattern woke from deep-sleep");

   property p_pm_wake;
      @(posedge clk) disable iff (!rst_n)
      ((|term_hit) && power_mode != pint_pkg::PINT_PWR_DEEP) |=> wake_req;
   endproperty
   a_pm_wake : assert property (p_pm_wake)
      else $error("pattern match did not wake from active or sleep");

   property p_slot_wake;
      @(posedge clk) disable iff (!rst_n)
      (|(req_w & wake_start_enable_0)) |=> wake_req;
   endproperty
   a_slot_wake : assert property (p_slot_wake)
      else $error("enabled slot request did not wake");

   property p_wake_idle;
      @(posedge clk) disable iff (!rst_n)
      (!(|(req_w & wake_start_enable_0)) && !(|term_hit)) |=> !wake_req;
   endproperty
   a_wake_idle : assert property (p_wake_idle)
      else $error("wake raised with no cause");
endmodule
`default_nettype wire
